/* File: verilog/prog_seq_consts.svh */
// constants for the program run/reset sequencer
`ifndef PROG_SEQ_CONSTS_SVH
`define PROG_SEQ_CONSTS_SVH
`define PRG_W 3
`define SEG_W 5
`define TIME_W 16
`define REP_W 8
`define SP_W 16
`define MV_W 16
`define SEG_TIME_CE 32'd1
`define PRESCALE_LEN_NS 32'd1000000
`define CLK_PERIOD_NS 32'd5
`define TICK_CYCLES (`PRESCALE_LEN_NS / `CLK_PERIOD_NS)
`define SEG_ZERO 5'h00
`endif

/* File: verilog/prog_seq_pkg.sv */
// types shared by the program run/reset sequencer
package prog_seq_pkg;
    typedef enum logic [1:0] {
        STARTUP_CONTINUE = 2'b00,
        STARTUP_RESET = 2'b01,
        STARTUP_RUN = 2'b10,
        STARTUP_MANUAL = 2'b11
    } startup_t;
    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_STANDBY = 2'b01,
        ST_RUN = 2'b10,
        ST_END = 2'b11
    } seq_state_t;
    typedef enum logic [1:0] {
        SPM_PROGRAM = 2'b00,
        SPM_FIXED = 2'b01,
        SPM_REMOTE = 2'b10
    } sp_mode_t;
endpackage : prog_seq_pkg

/* File: verilog/program_run_reset_sequencer.sv */
// program run/reset/hold sequencer with startup handling and live segment edits
// Functional notes
// - run starts the selected program; reset stops it
// - hold freezes segment advance and elapsed time until released
// - program selection accepted only in reset status
// - reset clears segment, elapsed time, repetitions, hold; loads program; cancels tuning
// - reset behaviour select picks stop control or fixed setpoint
// - stop control: reset halts control
// - stop control: reset output value driven throughout reset, output active if nonzero
// - run under fixed setpoint behaviour forces program setpoint mode
// - reset under fixed setpoint behaviour goes fixed/remote mode, control continues
// - fixed setpoint behaviour: segment 0 ramps from current setpoint to target
// - startup behaviour applied at power-on, software reset, leaving setup level
// - continue restores prior operating state
// - reset startup always comes up in reset
// - run startup restarts program from beginning, including standby
// - manual startup comes up manual; refused when manual is disabled
// - persistence of counters, hold, run and auto/manual per startup choice
// - run startup reloads full standby time
// - power lost in auto, manual startup: stop control gives manual value, else zero; code applies this only in reset status
// - edited segment target: setpoint moves linearly from present value while elapsed time is 0; later edits ramp from the segment start
// - edited segment time: slope recomputed to reach target at new end
// - edited time below elapsed time advances to next segment at once
`timescale 1ns/1ps
`include "prog_seq_consts.svh"
module program_run_reset_sequencer
    import prog_seq_pkg::*;
#(
    parameter int TICK_CYCLES = `TICK_CYCLES,
    parameter int NUM_SEG = 32
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_run_req,
    input wire logic i_hold_req,
    input wire logic [`PRG_W-1:0] i_prog_sel,
    input wire logic i_reset_behaviour_select,
    input wire logic [1:0] i_power_up_behaviour_select,
    input wire logic i_manual_disabled,
    input wire logic i_startup_evt,
    input wire logic i_manual_req,
    input wire logic [1:0] i_reset_sp_mode,
    input wire logic [`MV_W-1:0] i_reset_mv,
    input wire logic [`MV_W-1:0] i_manual_mv,
    input wire logic [`TIME_W-1:0] i_standby_time,
    input wire logic [`REP_W-1:0] i_repeat_count,
    input wire logic [`SEG_W-1:0] i_last_seg,
    input wire logic [`SP_W-1:0] i_fixed_sp,
    input wire logic [`SP_W-1:0] i_seg_target,
    input wire logic [`TIME_W-1:0] i_seg_time,
    output logic o_running,
    output logic o_hold,
    output logic [`PRG_W-1:0] o_prog_num,
    output logic [`SEG_W-1:0] o_seg_num,
    output logic [`TIME_W-1:0] o_elapsed,
    output logic [`TIME_W-1:0] o_standby_left,
    output logic [`REP_W-1:0] o_rep_cnt,
    output logic [1:0] o_sp_mode,
    output logic [`SP_W-1:0] o_present_sp,
    output logic o_control_on,
    output logic o_out_active,
    output logic [`MV_W-1:0] o_mv,
    output logic o_manual,
    output logic o_tune_cancel,
    output logic o_sel_refused
);
    typedef struct packed {
        logic [1:0] sync_run;
        logic [1:0] sync_hold;
        logic run_d;
        seq_state_t st;
        logic hold;
        logic [`PRG_W-1:0] prog;
        logic [`SEG_W-1:0] seg;
        logic [`TIME_W-1:0] elapsed;
        logic [`TIME_W-1:0] standby;
        logic [`REP_W-1:0] rep;
        logic [`SP_W-1:0] sp;
        logic [`SP_W-1:0] seg_start_sp;
        logic [1:0] sp_mode;
        logic manual;
        logic was_auto;
        logic [31:0] tick_cnt;
        logic tick;
        logic ctl_on;
        logic out_act;
        logic [`MV_W-1:0] mv;
        logic tune_cancel;
        logic refused;
        logic running;
        logic man_req_d;
    } state_t;

    state_t cur_ff;
    state_t nxt_ff;

    // linear interpolation from start setpoint to target over segment time
    function automatic logic [`SP_W-1:0] interp(input logic [`SP_W-1:0] from,
                                                input logic [`SP_W-1:0] to,
                                                input logic [`TIME_W-1:0] t,
                                                input logic [`TIME_W-1:0] len);
        logic signed [`SP_W+`TIME_W+1:0] diff;
        logic signed [`SP_W+`TIME_W+1:0] step;
        begin
            diff = $signed({2'b00, to}) - $signed({2'b00, from});
            if (len == '0 || t >= len) begin
                interp = to;
            end else begin
                step = (diff * $signed({2'b00, t})) / $signed({2'b00, len});
                interp = from + step[`SP_W-1:0];
            end
        end
    endfunction : interp

    wire logic run_s = cur_ff.sync_run[1];
    wire logic hold_s = cur_ff.sync_hold[1];
    wire logic fixed_beh = i_reset_behaviour_select;

    // next-state logic
    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.sync_run = {cur_ff.sync_run[0], i_run_req};
        nxt_ff.sync_hold = {cur_ff.sync_hold[0], i_hold_req};
        nxt_ff.run_d = run_s;
        nxt_ff.tune_cancel = 1'b0;
        nxt_ff.refused = 1'b0;
        nxt_ff.was_auto = ~cur_ff.manual;
        // timebase prescaler, one tick per time unit
        nxt_ff.tick = 1'b0;
        if (cur_ff.tick_cnt >= 32'(TICK_CYCLES - 1)) begin
            nxt_ff.tick_cnt = '0;
            nxt_ff.tick = 1'b1;
        end else begin
            nxt_ff.tick_cnt = cur_ff.tick_cnt + 32'd1;
        end
        // manual follows changes of its request, so a manual startup is not undone
        nxt_ff.man_req_d = i_manual_req;
        if (i_manual_disabled) begin
            nxt_ff.manual = 1'b0;
        end else if (i_manual_req != cur_ff.man_req_d) begin
            nxt_ff.manual = i_manual_req;
        end
        if (cur_ff.st == ST_RESET) begin
            nxt_ff.prog = i_prog_sel;
            nxt_ff.seg = `SEG_ZERO;
            nxt_ff.elapsed = '0;
            nxt_ff.rep = '0;
            nxt_ff.hold = 1'b0;
            nxt_ff.standby = i_standby_time;
            nxt_ff.seg_start_sp = cur_ff.sp;
            if (fixed_beh) begin
                // control keeps tracking the fixed or remote setpoint
                nxt_ff.sp_mode = (i_reset_sp_mode == 2'(SPM_REMOTE)) ? 2'(SPM_REMOTE)
                                                                   : 2'(SPM_FIXED);
                nxt_ff.sp = i_fixed_sp;
                nxt_ff.ctl_on = 1'b1;
                nxt_ff.mv = '0;
                nxt_ff.out_act = 1'b0;
            end else begin
                nxt_ff.ctl_on = 1'b0;
                nxt_ff.mv = i_reset_mv;
                nxt_ff.out_act = (i_reset_mv != '0);
            end
            if (run_s && !cur_ff.run_d) begin
                nxt_ff.st = (i_standby_time != '0) ? ST_STANDBY : ST_RUN;
                nxt_ff.sp_mode = 2'(SPM_PROGRAM);
                nxt_ff.ctl_on = 1'b1;
                nxt_ff.out_act = 1'b0;
            end
        end else begin
            if (i_prog_sel != cur_ff.prog) begin
                nxt_ff.refused = 1'b1;
            end
            nxt_ff.hold = hold_s;
            nxt_ff.ctl_on = 1'b1;
            unique case (cur_ff.st)
                ST_STANDBY: begin
                    if (cur_ff.tick && !hold_s) begin
                        if (cur_ff.standby <= `TIME_W'(1)) begin
                            nxt_ff.standby = '0;
                            nxt_ff.st = ST_RUN;
                        end else begin
                            nxt_ff.standby = cur_ff.standby - `TIME_W'(1);
                        end
                    end
                end
                ST_RUN: begin
                    // segment 0 ramps only under fixed behaviour; else a step
                    if (cur_ff.seg == `SEG_ZERO && !fixed_beh) begin
                        nxt_ff.sp = i_seg_target;
                    end else begin
                        nxt_ff.sp = interp(cur_ff.seg_start_sp, i_seg_target,
                                           cur_ff.elapsed, i_seg_time);
                    end
                    if (i_seg_target != cur_ff.sp && cur_ff.elapsed == '0) begin
                        nxt_ff.seg_start_sp = cur_ff.sp;
                    end
                    if (cur_ff.elapsed >= i_seg_time) begin
                        // covers a time edited below the elapsed time
                        nxt_ff.elapsed = '0;
                        nxt_ff.seg_start_sp = i_seg_target;
                        if (cur_ff.seg >= i_last_seg || cur_ff.seg == `SEG_W'(NUM_SEG - 1)) begin
                            nxt_ff.seg = `SEG_ZERO;
                            if (cur_ff.rep >= i_repeat_count) begin
                                nxt_ff.st = ST_END;
                            end else begin
                                nxt_ff.rep = cur_ff.rep + `REP_W'(1);
                            end
                        end else begin
                            nxt_ff.seg = cur_ff.seg + `SEG_W'(1);
                        end
                    end else if (cur_ff.tick && !hold_s) begin
                        nxt_ff.elapsed = cur_ff.elapsed + `TIME_W'(1);
                    end
                end
                ST_END: begin
                    nxt_ff.sp = i_seg_target;
                end
                ST_RESET: begin
                    nxt_ff.st = ST_RESET;
                end
            endcase
            nxt_ff.mv = cur_ff.manual ? i_manual_mv : '0;
            nxt_ff.out_act = cur_ff.manual && (i_manual_mv != '0);
            if (!run_s && cur_ff.run_d) begin
                nxt_ff.st = ST_RESET;
                nxt_ff.tune_cancel = 1'b1;
            end
        end
        // startup event: power-on release, software reset, setup exit
        if (i_startup_evt) begin
            unique case (startup_t'(i_power_up_behaviour_select))
                STARTUP_CONTINUE: begin
                    nxt_ff = cur_ff;
                    nxt_ff.sync_run = {cur_ff.sync_run[0], i_run_req};
                    nxt_ff.sync_hold = {cur_ff.sync_hold[0], i_hold_req};
                    nxt_ff.man_req_d = i_manual_req;
                end
                STARTUP_RESET: begin
                    nxt_ff.st = ST_RESET;
                    nxt_ff.seg = `SEG_ZERO;
                    nxt_ff.elapsed = '0;
                    nxt_ff.rep = '0;
                    nxt_ff.hold = 1'b0;
                    nxt_ff.manual = cur_ff.manual;
                end
                STARTUP_RUN: begin
                    nxt_ff.st = (i_standby_time != '0) ? ST_STANDBY : ST_RUN;
                    nxt_ff.standby = i_standby_time;
                    nxt_ff.seg = `SEG_ZERO;
                    nxt_ff.elapsed = '0;
                    nxt_ff.rep = '0;
                    nxt_ff.hold = 1'b0;
                    nxt_ff.sp_mode = 2'(SPM_PROGRAM);
                    nxt_ff.manual = cur_ff.manual;
                end
                STARTUP_MANUAL: begin
                    if (!i_manual_disabled) begin
                        nxt_ff = cur_ff;
                        // synchronisers keep moving while the rest is held
                        nxt_ff.sync_run = {cur_ff.sync_run[0], i_run_req};
                        nxt_ff.sync_hold = {cur_ff.sync_hold[0], i_hold_req};
                        nxt_ff.man_req_d = i_manual_req;
                        nxt_ff.manual = 1'b1;
                        if (cur_ff.was_auto && cur_ff.st == ST_RESET) begin
                            nxt_ff.mv = fixed_beh ? '0 : i_manual_mv;
                            nxt_ff.out_act = !fixed_beh && (i_manual_mv != '0);
                        end
                    end else begin
                        nxt_ff.refused = 1'b1;
                    end
                end
            endcase
        end
        // running flag registered so the output comes straight from a flop
        nxt_ff.running = (nxt_ff.st != ST_RESET);
    end

    // single state register; clock enable freezes everything
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cur_ff <= '0;
        end else if (i_ce) begin
            cur_ff <= nxt_ff;
        end
    end

    assign o_running = cur_ff.running;
    assign o_hold = cur_ff.hold;
    assign o_prog_num = cur_ff.prog;
    assign o_seg_num = cur_ff.seg;
    assign o_elapsed = cur_ff.elapsed;
    assign o_standby_left = cur_ff.standby;
    assign o_rep_cnt = cur_ff.rep;
    assign o_sp_mode = cur_ff.sp_mode;
    assign o_present_sp = cur_ff.sp;
    assign o_control_on = cur_ff.ctl_on;
    assign o_out_active = cur_ff.out_act;
    assign o_mv = cur_ff.mv;
    assign o_manual = cur_ff.manual;
    assign o_tune_cancel = cur_ff.tune_cancel;
    assign o_sel_refused = cur_ff.refused;

    // checks
    property p_reset_clears;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_ce && !i_startup_evt && cur_ff.st == ST_RESET) |=> (o_seg_num == '0 && o_rep_cnt == '0);
    endproperty
    a_reset_clears: assert property (p_reset_clears) else $error("reset left counters");
    property p_stop_mv;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_ce && !i_startup_evt && cur_ff.st == ST_RESET && !fixed_beh) |=> (o_mv == $past(i_reset_mv));
    endproperty
    a_stop_mv: assert property (p_stop_mv) else $error("reset mv not driven");
    property p_stop_halts;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_ce && !i_startup_evt && cur_ff.st == ST_RESET && !fixed_beh && !(run_s && !cur_ff.run_d))
        |=> !o_control_on;
    endproperty
    a_stop_halts: assert property (p_stop_halts) else $error("control not halted");
    property p_hold_freeze;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_ce && !i_startup_evt && cur_ff.st == ST_RUN && hold_s && run_s && cur_ff.run_d
         && cur_ff.elapsed < i_seg_time) |=> $stable(o_elapsed);
    endproperty
    a_hold_freeze: assert property (p_hold_freeze) else $error("hold did not freeze");
    property p_prog_locked;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_ce && !i_startup_evt && cur_ff.st != ST_RESET) |=> $stable(o_prog_num);
    endproperty
    a_prog_locked: assert property (p_prog_locked) else $error("program changed in run");
    property p_run_starts;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_ce && !i_startup_evt && cur_ff.st == ST_RESET && run_s && !cur_ff.run_d)
        |=> (o_running && o_sp_mode == 2'(SPM_PROGRAM));
    endproperty
    a_run_starts: assert property (p_run_starts) else $error("run not started");
    property p_fixed_keeps;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_ce && !i_startup_evt && cur_ff.st == ST_RESET && fixed_beh && !(run_s && !cur_ff.run_d))
        |=> (o_control_on && o_sp_mode != 2'(SPM_PROGRAM));
    endproperty
    a_fixed_keeps: assert property (p_fixed_keeps) else $error("fixed mode stopped");
    property p_startup_reset;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_ce && i_startup_evt && i_power_up_behaviour_select == 2'(STARTUP_RESET)) |=> !o_running;
    endproperty
    a_startup_reset: assert property (p_startup_reset) else $error("startup not reset");
    property p_manual_refused;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_ce && i_startup_evt && i_manual_disabled
         && i_power_up_behaviour_select == 2'(STARTUP_MANUAL)) |=> (o_sel_refused && !o_manual);
    endproperty
    a_manual_refused: assert property (p_manual_refused) else $error("manual accepted");
    c_run: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) cur_ff.st == ST_RUN);
    c_end: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) cur_ff.st == ST_END);
    c_hold: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) o_hold && o_running);
endmodule : program_run_reset_sequencer

/* File: test/operator_panel.sv */
// behavioural model of the operator keys / event inputs driving run, hold and program choice
`timescale 1ns/1ps
`include "prog_seq_consts.svh"
module operator_panel (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_running,
    input wire logic i_slow,
    input wire logic i_sel_anytime,
    input wire logic i_run_cmd,
    input wire logic i_hold_cmd,
    input wire logic [`PRG_W-1:0] i_sel_cmd,
    output logic o_run_req,
    output logic o_hold_req,
    output logic [`PRG_W-1:0] o_prog_sel
);
    int lag_cnt = 0;
    // levels move just after the falling edge; slow mode mimics a lazy key scan
    always @(negedge i_sys_clk) begin
        if (!i_rst_n) begin
            lag_cnt <= 0;
            o_run_req <= 1'b0;
            o_hold_req <= 1'b0;
            o_prog_sel <= '0;
        end else if (i_slow && lag_cnt < 3) begin
            lag_cnt <= lag_cnt + 1;
        end else begin
            lag_cnt <= 0;
            o_run_req <= i_run_cmd;
            o_hold_req <= i_hold_cmd;
            // choice only offered in reset unless a refusal is wanted
            if (!i_running || i_sel_anytime) begin
                o_prog_sel <= i_sel_cmd;
            end
        end
    end
endmodule : operator_panel

/* File: test/tb.sv */
// self-checking bench for the program run/reset sequencer
`timescale 1ns/1ps
`include "prog_seq_consts.svh"
module tb;
    import prog_seq_pkg::*;
    localparam int TICK = 16; // short tick keeps segments tens of cycles long
    typedef struct {string name; logic [15:0] exp;} note_t;
    logic i_sys_clk, i_rst_n = 1'b0, i_ce = 1'b1, i_reset_behaviour_select = 1'b0;
    logic i_manual_disabled = 1'b0, i_startup_evt = 1'b0, i_manual_req = 1'b0;
    logic run_cmd = 1'b0, hold_cmd = 1'b0, slow = 1'b0, sel_any = 1'b0, run_req, hold_req;
    logic [1:0] i_power_up_behaviour_select = 2'h1, i_reset_sp_mode = 2'h1, o_sp_mode;
    logic [`PRG_W-1:0] sel_cmd = '0, prog_sel, o_prog_num;
    logic [`MV_W-1:0] i_reset_mv = '0, i_manual_mv = 16'h0040, o_mv;
    logic [`TIME_W-1:0] i_standby_time = '0, i_seg_time = 16'h0002, o_elapsed, o_standby_left;
    logic [`REP_W-1:0] i_repeat_count = 8'h03, o_rep_cnt;
    logic [`SEG_W-1:0] i_last_seg = 5'h1f, o_seg_num;
    logic [`SP_W-1:0] i_fixed_sp = '0, i_seg_target = '0, o_present_sp;
    logic o_running, o_hold, o_control_on, o_out_active, o_manual, o_tune_cancel, o_sel_refused;
    logic [31:0] lfsr_q = 32'h2d92;
    int errors = 0, n_compared = 0, cycles = 0;
    note_t notes[$];

    operator_panel u_panel (.i_sys_clk, .i_rst_n, .i_running(o_running), .i_slow(slow),
        .i_sel_anytime(sel_any), .i_run_cmd(run_cmd), .i_hold_cmd(hold_cmd),
        .i_sel_cmd(sel_cmd), .o_run_req(run_req), .o_hold_req(hold_req), .o_prog_sel(prog_sel));
    program_run_reset_sequencer #(.TICK_CYCLES(TICK), .NUM_SEG(32)) u_dut (
        .i_sys_clk, .i_rst_n, .i_ce, .i_run_req(run_req), .i_hold_req(hold_req),
        .i_prog_sel(prog_sel), .i_reset_behaviour_select, .i_power_up_behaviour_select,
        .i_manual_disabled, .i_startup_evt, .i_manual_req, .i_reset_sp_mode, .i_reset_mv,
        .i_manual_mv, .i_standby_time, .i_repeat_count, .i_last_seg, .i_fixed_sp,
        .i_seg_target, .i_seg_time, .o_running, .o_hold, .o_prog_num, .o_seg_num, .o_elapsed,
        .o_standby_left, .o_rep_cnt, .o_sp_mode, .o_present_sp, .o_control_on, .o_out_active,
        .o_mv, .o_manual, .o_tune_cancel, .o_sel_refused);

    // 200 MHz system clock
    initial begin
        i_sys_clk = 1'b0;
        forever #2.5 i_sys_clk = ~i_sys_clk;
    end

    function logic [31:0] lfsr_next(input logic [31:0] s);
        lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    // output picked by name, zero-extended to 16 bits
    function logic [15:0] obs(input string n);
        case (n)
            "run": obs = 16'(o_running);
            "hold": obs = 16'(o_hold);
            "prog": obs = 16'(o_prog_num);
            "seg": obs = 16'(o_seg_num);
            "elapsed": obs = o_elapsed;
            "standby": obs = o_standby_left;
            "rep": obs = 16'(o_rep_cnt);
            "spmode": obs = 16'(o_sp_mode);
            "sp": obs = o_present_sp;
            "ctrl": obs = 16'(o_control_on);
            "active": obs = 16'(o_out_active);
            "mv": obs = o_mv;
            "manual": obs = 16'(o_manual);
            "tune": obs = 16'(o_tune_cancel);
            "refused": obs = 16'(o_sel_refused);
            default: obs = 'x;
        endcase
    endfunction : obs

    task check(input string n, input logic [15:0] exp, input logic [15:0] seen);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask : check

    task stop_test;
        if (errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test

    task cyc(input int n);
        repeat (n) @(negedge i_sys_clk);
    endtask : cyc

    task expect_out(input string n, input logic [15:0] v);
        notes.push_back('{n, v});
    endtask : expect_out

    // bounded wait; a miss shows up as a mismatch in the watcher
    task wait_for(input string n, input logic [15:0] v, input int lim);
        int k;
        k = 0;
        while (obs(n) !== v && k < lim) begin
            cyc(1);
            k++;
        end
        expect_out(n, v);
    endtask : wait_for

    task startup;
        i_startup_evt = 1'b1;
        cyc(1);
        i_startup_evt = 1'b0;
    endtask : startup

    // watcher: compares every pending note once the falling edge has settled
    initial begin : watch
        note_t nt;
        forever begin
            @(negedge i_sys_clk);
            #1;
            while (notes.size() > 0) begin
                nt = notes.pop_front();
                check(nt.name, nt.exp, obs(nt.name));
            end
        end
    end

    // hang guard well above the expected run length
    always @(posedge i_sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            errors++;
            stop_test();
        end
    end

    initial begin : main
        logic [`PRG_W-1:0] p0;
        logic [15:0] snap;
        cyc(5);
        i_rst_n = 1'b1;
        // reset status under stop control with random program and values
        lfsr_q = lfsr_next(lfsr_q);
        p0 = lfsr_q[2:0];
        sel_cmd = p0;
        i_reset_mv = lfsr_q[15:0] | 16'h0001; // nonzero: output must stay active
        i_fixed_sp = lfsr_q[31:16];
        i_seg_target = ~lfsr_q[31:16];
        cyc(1);
        wait_for("prog", 16'(p0), 10);
        wait_for("mv", i_reset_mv, 5);
        expect_out("active", 16'h1);
        expect_out("ctrl", 16'h0);
        expect_out("seg", 16'h0);
        // run through segment 0 with a slow key scan
        slow = 1'b1;
        run_cmd = 1'b1;
        wait_for("run", 16'h1, 30);
        slow = 1'b0;
        expect_out("spmode", 16'h0);
        wait_for("seg", 16'h1, 3 * TICK + 10);
        i_seg_time = 16'h00ff;
        // program change while running is refused
        sel_any = 1'b1;
        sel_cmd = p0 + 3'h1;
        wait_for("refused", 16'h1, 10);
        expect_out("prog", 16'(p0));
        sel_cmd = p0;
        cyc(2);
        sel_any = 1'b0;
        // hold freezes elapsed time and segment
        hold_cmd = 1'b1;
        wait_for("hold", 16'h1, 10);
        cyc(1);
        snap = obs("elapsed");
        cyc(3 * TICK);
        expect_out("elapsed", snap);
        expect_out("seg", 16'h1);
        hold_cmd = 1'b0;
        wait_for("hold", 16'h0, 10);
        // time edited below elapsed jumps on at once
        cyc(3 * TICK);
        i_seg_time = 16'h0001;
        wait_for("seg", 16'h2, 10);
        i_seg_time = 16'h00ff;
        // back to reset clears the counters
        run_cmd = 1'b0;
        wait_for("tune", 16'h1, 10);
        wait_for("run", 16'h0, 3);
        cyc(1); // counters clear on the first edge spent in reset status
        expect_out("seg", 16'h0);
        expect_out("elapsed", 16'h0);
        expect_out("rep", 16'h0);
        expect_out("ctrl", 16'h0);
        // fixed setpoint reset behaviour, fixed then remote
        i_reset_behaviour_select = 1'b1;
        for (int m = 1; m <= 2; m++) begin
            i_reset_sp_mode = 2'(m);
            wait_for("spmode", 16'(m), 10);
            expect_out("ctrl", 16'h1);
            run_cmd = 1'b1;
            wait_for("run", 16'h1, 20);
            expect_out("spmode", 16'h0);
            if (m == 1) begin
                // one edge into segment 0 a ramp still sits at its start, a step would not
                cyc(1);
                expect_out("sp", i_fixed_sp);
            end
            run_cmd = 1'b0;
            wait_for("spmode", 16'(m), 20);
            expect_out("ctrl", 16'h1);
        end
        // startup behaviours from a running program in segment 1
        i_reset_behaviour_select = 1'b0;
        run_cmd = 1'b1;
        wait_for("run", 16'h1, 20);
        i_seg_time = 16'h0001;
        wait_for("seg", 16'h1, 2 * TICK + 10);
        i_seg_time = 16'h00ff;
        i_power_up_behaviour_select = 2'h0;
        startup();
        cyc(2);
        expect_out("run", 16'h1);
        expect_out("seg", 16'h1);
        i_standby_time = 16'h0007;
        i_power_up_behaviour_select = 2'h2;
        startup();
        i_ce = 1'b0; // frozen so the standby count is read before a tick
        cyc(2);
        expect_out("seg", 16'h0);
        expect_out("elapsed", 16'h0);
        expect_out("standby", 16'h0007);
        i_ce = 1'b1;
        i_standby_time = 16'h0000;
        i_power_up_behaviour_select = 2'h3;
        i_manual_disabled = 1'b1;
        startup();
        expect_out("refused", 16'h1);
        cyc(2);
        expect_out("manual", 16'h0);
        i_manual_disabled = 1'b0;
        startup();
        wait_for("manual", 16'h1, 5);
        i_power_up_behaviour_select = 2'h1;
        startup();
        wait_for("run", 16'h0, 5);
        expect_out("seg", 16'h0);
        expect_out("prog", 16'(p0));
        cyc(3);
        stop_test();
    end
endmodule : tb
